// File: lane_health_pkg.sv
// Constants shared by the lane status register block and its evaluators.
package lane_health_pkg;

	// Width of the configuration port address.
	localparam int ADDR_W = 12;

	// Width of a status register and of the error counters and limit.
	localparam int DATA_W = 8;

	// Offsets of the two lane status registers on the configuration port.
	localparam logic [ADDR_W-1:0] LANE2_LINK_HEALTH_OFS = 12'h4b2;
	localparam logic [ADDR_W-1:0] LANE3_LINK_HEALTH_OFS = 12'h4b3;

	// Value of every status register after reset.
	localparam logic [DATA_W-1:0] LINK_HEALTH_RESET = 8'h00;

	// Value returned for a read of an address that holds no register here.
	localparam logic [DATA_W-1:0] UNMAPPED_READ_VALUE = 8'h00;

	// Field positions inside a lane status register.
	localparam int DISPARITY_OVER_LIMIT_BIT     = 7;
	localparam int BAD_CODE_OVER_LIMIT_BIT      = 6;
	localparam int STRAY_CONTROL_OVER_LIMIT_BIT = 5;
	localparam int DESKEW_OK_BIT                = 4;
	localparam int ALIGNMENT_OK_BIT             = 3;
	localparam int CHECKSUM_OK_BIT              = 2;
	localparam int FRAME_LOCKED_BIT             = 1;
	localparam int CODE_GROUP_LOCKED_BIT        = 0;

	// Cycles from a live input change to the status register holding it.
	localparam int STATUS_LATENCY = 1;

	// Cycles from an accepted read to valid read data.
	localparam int READ_LATENCY = 1;

endpackage

// File: lane_status_if.sv
// Signals that carry one lane's live status into its evaluator and the result back.
`timescale 1ns/1ps
interface lane_status_if;

	// Live error counts from the lane's counters.
	logic [lane_health_pkg::DATA_W-1:0] disparityCount;
	logic [lane_health_pkg::DATA_W-1:0] badCodeCount;
	logic [lane_health_pkg::DATA_W-1:0] strayControlCount;

	// Shared error-count limit.
	logic [lane_health_pkg::DATA_W-1:0] errorCountLimit;

	// Live synchronisation flags from the lane decoder.
	logic                               deskewOk;
	logic                               alignmentOk;
	logic                               checksumOk;
	logic                               frameLocked;
	logic                               codeGroupLocked;

	// Registered status byte of the lane.
	logic [lane_health_pkg::DATA_W-1:0] statusByte;

	// The register block feeds the inputs and reads the byte.
	modport feed (
		output disparityCount, badCodeCount, strayControlCount, errorCountLimit,
		output deskewOk, alignmentOk, checksumOk, frameLocked, codeGroupLocked,
		input  statusByte
	);

	// The evaluator reads the inputs and produces the byte.
	modport eval (
		input  disparityCount, badCodeCount, strayControlCount, errorCountLimit,
		input  deskewOk, alignmentOk, checksumOk, frameLocked, codeGroupLocked,
		output statusByte
	);

endinterface

// File: lane_status_eval.sv
// Evaluator that builds one lane's registered status byte from live inputs.
`timescale 1ns/1ps
module lane_status_eval (
	// Clock, reset and enable.
	input  wire logic  sys_clk,
	input  wire logic  rst_n,
	input  wire logic  clkEn,
	// Lane inputs and status result.
	lane_status_if.eval lane
);

	// All state of the evaluator.
	typedef struct packed {
		logic [lane_health_pkg::DATA_W-1:0] status; // Status byte as software reads it.
	} eval_state_t;

	eval_state_t state_q; // Registered state.
	eval_state_t state_d; // Next state.

	// Compare the live counters with the limit and pack the flags into the byte.
	always_comb begin
		state_d = state_q;
		state_d.status = lane_health_pkg::LINK_HEALTH_RESET;
		state_d.status[lane_health_pkg::DISPARITY_OVER_LIMIT_BIT] =
			(lane.disparityCount >= lane.errorCountLimit);
		state_d.status[lane_health_pkg::BAD_CODE_OVER_LIMIT_BIT] =
			(lane.badCodeCount >= lane.errorCountLimit);
		state_d.status[lane_health_pkg::STRAY_CONTROL_OVER_LIMIT_BIT] =
			(lane.strayControlCount >= lane.errorCountLimit);
		state_d.status[lane_health_pkg::DESKEW_OK_BIT]         = lane.deskewOk;
		state_d.status[lane_health_pkg::ALIGNMENT_OK_BIT]      = lane.alignmentOk;
		state_d.status[lane_health_pkg::CHECKSUM_OK_BIT]       = lane.checksumOk;
		state_d.status[lane_health_pkg::FRAME_LOCKED_BIT]      = lane.frameLocked;
		// Code group lock is copied from the lane input without any gating.
		state_d.status[lane_health_pkg::CODE_GROUP_LOCKED_BIT] = lane.codeGroupLocked;
	end

	// Register the state; the enable freezes it and reset clears every flag.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q.status <= lane_health_pkg::LINK_HEALTH_RESET;
		end else if (clkEn) begin
			state_q <= state_d;
		end
	end

	// The byte always comes straight from the register.
	assign lane.statusByte = state_q.status;

	// Disparity flag follows the comparison one enabled cycle later.
	// Reset is in the antecedent so that the edge which releases it starts no attempt.
	a_disparity_threshold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rst_n && clkEn |=> lane.statusByte[lane_health_pkg::DISPARITY_OVER_LIMIT_BIT] ==
			($past(lane.disparityCount) >= $past(lane.errorCountLimit)))
		else $error("Disparity flag does not match count against limit.");

	// Bad code flag follows the comparison one enabled cycle later.
	a_bad_code_threshold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rst_n && clkEn |=> lane.statusByte[lane_health_pkg::BAD_CODE_OVER_LIMIT_BIT] ==
			($past(lane.badCodeCount) >= $past(lane.errorCountLimit)))
		else $error("Bad code flag does not match count against limit.");

	// Stray control flag follows the comparison one enabled cycle later.
	a_stray_ctrl_threshold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rst_n && clkEn |=> lane.statusByte[lane_health_pkg::STRAY_CONTROL_OVER_LIMIT_BIT] ==
			($past(lane.strayControlCount) >= $past(lane.errorCountLimit)))
		else $error("Stray control flag does not match count against limit.");

	// Reset leaves the status byte at zero.
	a_reset_clears_byte: assert property (@(posedge sys_clk)
		!rst_n |=> lane.statusByte == lane_health_pkg::LINK_HEALTH_RESET)
		else $error("Status byte not cleared by reset.");

	// While frozen, the status byte keeps its value.
	a_enable_freezes_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rst_n && !clkEn |=> $stable(lane.statusByte))
		else $error("Status byte changed while clock enable was low.");

endmodule

// File: serial_lane_status_regs.sv
// Read-only link status registers for serial receiver lanes 2 and 3.
`timescale 1ns/1ps

module serial_lane_status_regs (
	// Clock, reset and clock enable.
	input  wire logic                               sys_clk,
	input  wire logic                               rst_n,
	input  wire logic                               clkEn,
	// Configuration port.
	input  wire logic [lane_health_pkg::ADDR_W-1:0] cfgAddr,
	input  wire logic                               cfgRead,
	input  wire logic                               cfgWrite,
	output logic      [lane_health_pkg::DATA_W-1:0] cfgRdData,
	output logic                                    cfgRdValid,
	// Shared error-count limit.
	input  wire logic [lane_health_pkg::DATA_W-1:0] errorCountLimit,
	// Lane 2 error counters.
	input  wire logic [lane_health_pkg::DATA_W-1:0] lane2DisparityCount,
	input  wire logic [lane_health_pkg::DATA_W-1:0] lane2BadCodeCount,
	input  wire logic [lane_health_pkg::DATA_W-1:0] lane2StrayControlCount,
	// Lane 2 synchronisation flags.
	input  wire logic                               lane2DeskewOk,
	input  wire logic                               lane2AlignmentOk,
	input  wire logic                               lane2ChecksumOk,
	input  wire logic                               lane2FrameLocked,
	input  wire logic                               lane2CodeGroupLocked,
	// Lane 3 error counters.
	input  wire logic [lane_health_pkg::DATA_W-1:0] lane3DisparityCount,
	input  wire logic [lane_health_pkg::DATA_W-1:0] lane3BadCodeCount,
	input  wire logic [lane_health_pkg::DATA_W-1:0] lane3StrayControlCount,
	// Lane 3 synchronisation flags.
	input  wire logic                               lane3DeskewOk,
	input  wire logic                               lane3AlignmentOk,
	input  wire logic                               lane3ChecksumOk,
	input  wire logic                               lane3FrameLocked,
	input  wire logic                               lane3CodeGroupLocked
);

	// Carriers between this block and the two lane evaluators.
	lane_status_if lane2Bus ();
	lane_status_if lane3Bus ();

	// Feed lane 2: counters and the shared limit.
	assign lane2Bus.disparityCount    = lane2DisparityCount;
	assign lane2Bus.badCodeCount      = lane2BadCodeCount;
	assign lane2Bus.strayControlCount = lane2StrayControlCount;
	assign lane2Bus.errorCountLimit   = errorCountLimit;
	// Feed lane 2: synchronisation flags.
	assign lane2Bus.deskewOk          = lane2DeskewOk;
	assign lane2Bus.alignmentOk       = lane2AlignmentOk;
	assign lane2Bus.checksumOk        = lane2ChecksumOk;
	assign lane2Bus.frameLocked       = lane2FrameLocked;
	assign lane2Bus.codeGroupLocked   = lane2CodeGroupLocked;

	// Feed lane 3: counters and the shared limit.
	assign lane3Bus.disparityCount    = lane3DisparityCount;
	assign lane3Bus.badCodeCount      = lane3BadCodeCount;
	assign lane3Bus.strayControlCount = lane3StrayControlCount;
	assign lane3Bus.errorCountLimit   = errorCountLimit;
	// Feed lane 3: synchronisation flags.
	assign lane3Bus.deskewOk          = lane3DeskewOk;
	assign lane3Bus.alignmentOk       = lane3AlignmentOk;
	assign lane3Bus.checksumOk        = lane3ChecksumOk;
	assign lane3Bus.frameLocked       = lane3FrameLocked;
	assign lane3Bus.codeGroupLocked   = lane3CodeGroupLocked;

	// Evaluator that keeps the lane 2 status register.
	lane_status_eval lane2Eval (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.lane    (lane2Bus.eval)
	);

	// Evaluator that keeps the lane 3 status register.
	lane_status_eval lane3Eval (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.lane    (lane3Bus.eval)
	);

	// All state of the read path.
	typedef struct packed {
		logic [lane_health_pkg::DATA_W-1:0] rdData;  // Data of the last read.
		logic                               rdValid; // One-cycle read answer strobe.
	} read_state_t;

	read_state_t state_q; // Registered state.
	read_state_t state_d; // Next state.

	// Decode a read; writes reach no storage, so they are dropped here.
	always_comb begin
		state_d = state_q;
		state_d.rdValid = 1'b0;
		// Only a read produces an answer; a write alone leaves the port idle.
		if (cfgRead) begin
			state_d.rdValid = 1'b1;
			case (cfgAddr)
				// Lane 2 register.
				lane_health_pkg::LANE2_LINK_HEALTH_OFS: begin
					state_d.rdData = lane2Bus.statusByte;
				end
				// Lane 3 register.
				lane_health_pkg::LANE3_LINK_HEALTH_OFS: begin
					state_d.rdData = lane3Bus.statusByte;
				end
				// Any other address answers with a fixed value.
				default: begin
					state_d.rdData = lane_health_pkg::UNMAPPED_READ_VALUE;
				end
			endcase
		end
	end

	// Register the read path; the enable freezes it, reset clears it.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q.rdData  <= lane_health_pkg::LINK_HEALTH_RESET;
			state_q.rdValid <= 1'b0;
		end else if (clkEn) begin
			state_q <= state_d;
		end
	end

	// Port outputs come from the registers.
	assign cfgRdData  = state_q.rdData;
	assign cfgRdValid = state_q.rdValid;

	// An enabled read of the lane 2 register with the input sampled one edge before.
	sequence s_lane2_read;
		$past(rst_n) && $past(clkEn) && clkEn && cfgRead &&
			(cfgAddr == lane_health_pkg::LANE2_LINK_HEALTH_OFS);
	endsequence

	// An enabled read of the lane 3 register with the input sampled one edge before.
	sequence s_lane3_read;
		$past(rst_n) && $past(clkEn) && clkEn && cfgRead &&
			(cfgAddr == lane_health_pkg::LANE3_LINK_HEALTH_OFS);
	endsequence

	// Lane 2 deskew flag reaches the read data two edges after the input.
	a_lane2_deskew_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_lane2_read |=> cfgRdValid &&
			(cfgRdData[lane_health_pkg::DESKEW_OK_BIT] == $past(lane2DeskewOk, 2)))
		else $error("Lane 2 deskew flag read back wrong.");

	// Lane 3 alignment flag reaches the read data two edges after the input.
	a_lane3_align_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_lane3_read |=> cfgRdValid &&
			(cfgRdData[lane_health_pkg::ALIGNMENT_OK_BIT] == $past(lane3AlignmentOk, 2)))
		else $error("Lane 3 alignment flag read back wrong.");

	// Lane 2 checksum flag reaches the read data two edges after the input.
	a_lane2_checksum_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_lane2_read |=>
			cfgRdData[lane_health_pkg::CHECKSUM_OK_BIT] == $past(lane2ChecksumOk, 2))
		else $error("Lane 2 checksum flag read back wrong.");

	// Lane 3 frame lock flag reaches the read data two edges after the input.
	a_lane3_frame_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_lane3_read |=>
			cfgRdData[lane_health_pkg::FRAME_LOCKED_BIT] == $past(lane3FrameLocked, 2))
		else $error("Lane 3 frame lock flag read back wrong.");

	// Code group lock of both lanes reaches the read data two edges after the input.
	a_code_group_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_lane2_read |=> cfgRdData[lane_health_pkg::CODE_GROUP_LOCKED_BIT] ==
			$past(lane2CodeGroupLocked, 2)) and
		(s_lane3_read |=> cfgRdData[lane_health_pkg::CODE_GROUP_LOCKED_BIT] ==
			$past(lane3CodeGroupLocked, 2)))
		else $error("Code group lock flag read back wrong.");

	// Lane 3 disparity flag read back matches count against limit.
	a_lane3_disparity_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_lane3_read |=> cfgRdData[lane_health_pkg::DISPARITY_OVER_LIMIT_BIT] ==
			($past(lane3DisparityCount, 2) >= $past(errorCountLimit, 2)))
		else $error("Lane 3 disparity flag read back wrong.");

	// A write without a read never produces an answer.
	a_write_no_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clkEn && cfgWrite && !cfgRead) |=> !cfgRdValid)
		else $error("Write produced a read answer.");

	// A read of an unmapped address answers zero.
	a_unmapped_read_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rst_n && clkEn && cfgRead && (cfgAddr != lane_health_pkg::LANE2_LINK_HEALTH_OFS) &&
			(cfgAddr != lane_health_pkg::LANE3_LINK_HEALTH_OFS)) |=>
			cfgRdValid && (cfgRdData == lane_health_pkg::UNMAPPED_READ_VALUE))
		else $error("Unmapped read did not answer zero.");

	// Reset clears the read port outputs.
	a_reset_read_port: assert property (@(posedge sys_clk)
		!rst_n |=> !cfgRdValid && (cfgRdData == lane_health_pkg::LINK_HEALTH_RESET))
		else $error("Read port not cleared by reset.");

endmodule

// File: serial_lane_status_regs_tb.sv
// Self-checking testbench for the lane 2 and lane 3 link status registers.
`timescale 1ns/1ps
module serial_lane_status_regs_tb;

	// Clock, reset and enable driven by the bench.
	logic                               sys_clk;
	logic                               rst_n;
	logic                               clkEn;
	// Configuration port signals.
	logic [lane_health_pkg::ADDR_W-1:0] cfgAddr;
	logic                               cfgRead;
	logic                               cfgWrite;
	logic [lane_health_pkg::DATA_W-1:0] cfgRdData;
	logic                               cfgRdValid;
	// Shared limit and per-lane counts; flags are {deskew, align, checksum, frame, codegroup}.
	logic [7:0]                         lim;
	logic [7:0]                         d2, b2, s2, d3, b3, s3;
	logic [4:0]                         f2, f3;
	// Next values chosen for the live inputs before they are driven on an edge.
	logic [7:0]                         nl, nd2, nb2, ns2, nd3, nb3, ns3;
	logic [4:0]                         nf2, nf3;
	// Addresses that hold no register here.
	logic [lane_health_pkg::ADDR_W-1:0] unmappedAddr [4] = '{12'h000, 12'h4b1, 12'h4b4, 12'hfff};
	// Expected read answers, oldest first, with the name of what was read.
	logic [7:0]                         expQ[$];
	string                              nameQ[$];
	// Result counters.
	int                                 numErrors;
	int                                 nChecks;

	serial_lane_status_regs i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
		.cfgAddr(cfgAddr), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
		.cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .errorCountLimit(lim),
		.lane2DisparityCount(d2), .lane2BadCodeCount(b2), .lane2StrayControlCount(s2),
		.lane2DeskewOk(f2[4]), .lane2AlignmentOk(f2[3]), .lane2ChecksumOk(f2[2]),
		.lane2FrameLocked(f2[1]), .lane2CodeGroupLocked(f2[0]),
		.lane3DisparityCount(d3), .lane3BadCodeCount(b3), .lane3StrayControlCount(s3),
		.lane3DeskewOk(f3[4]), .lane3AlignmentOk(f3[3]), .lane3ChecksumOk(f3[2]),
		.lane3FrameLocked(f3[1]), .lane3CodeGroupLocked(f3[0])
	);

	// The clock runs at 25 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Compares one value and reports a mismatch at once.
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expd);
		nChecks++;
		if (seen !== expd) begin
			numErrors++;
			$display("[ERR] %s expected %h seen %h", what, expd, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic closeOut();
		$display("checks %0d errors %0d", nChecks, numErrors);
		if (numErrors == 0 && nChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Builds the expected status byte of one lane from its live inputs.
	function automatic logic [7:0] expByte(input logic [7:0] lm, dc, bc, sc, input logic [4:0] fl);
		return {dc >= lm, bc >= lm, sc >= lm, fl};
	endfunction

	// Presents one read and notes the answer it must give.
	task automatic readReg(input logic [11:0] addr, input logic [7:0] expd, input string what);
		@(posedge sys_clk);
		cfgRead <= 1'b1;
		cfgAddr <= addr;
		expQ.push_back(expd);
		nameQ.push_back(what);
	endtask

	// Drops every request for one cycle.
	task automatic idle();
		@(posedge sys_clk);
		cfgRead  <= 1'b0;
		cfgWrite <= 1'b0;
	endtask

	// Picks a count just below, at or above the limit, or anywhere.
	function automatic logic [7:0] pick(input logic [7:0] lm);
		case ($urandom_range(0, 3))
			0:       return lm - 8'h01;
			1:       return lm;
			2:       return lm + 8'h01;
			default: return 8'($urandom);
		endcase
	endfunction

	// Every answer strobe takes the oldest note off the queue and compares.
	always @(posedge sys_clk) begin
		if (rst_n === 1'b1 && cfgRdValid !== 1'b0) begin
			if (expQ.size() == 0) begin
				check("unexpected answer", {7'h00, cfgRdValid}, 8'h00);
			end else begin
				check(nameQ.pop_front(), cfgRdData, expQ.pop_front());
			end
		end
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (5000) @(posedge sys_clk);
		numErrors++;
		closeOut();
	end

	// Main sequence.
	initial begin
		numErrors = 0;
		nChecks   = 0;
		void'($urandom(32'hbf3db8d3));
		rst_n = 1'b0; clkEn = 1'b1; cfgRead = 1'b1; cfgWrite = 1'b0;
		cfgAddr = lane_health_pkg::LANE2_LINK_HEALTH_OFS;
		lim = 8'h00; d2 = 8'hff; b2 = 8'hff; s2 = 8'hff; d3 = 8'hff; b3 = 8'hff; s3 = 8'hff;
		f2 = 5'h1f; f3 = 5'h1f;
		// Reset holds outputs at zero even with a read pending, all counts and flags high and the limit at zero.
		repeat (7) @(posedge sys_clk);
		#1;
		check("reset read data", cfgRdData, lane_health_pkg::LINK_HEALTH_RESET);
		check("reset valid", {7'h00, cfgRdValid}, 8'h00);
		@(posedge sys_clk);
		rst_n   <= 1'b1;
		cfgRead <= 1'b0;
		// Random live inputs, each lane read back to back.
		for (int i = 0; i < 60; i++) begin
			@(posedge sys_clk);
			cfgRead <= 1'b0;
			nl = (i < 30) ? 8'($urandom_range(0, 3)) : 8'($urandom);
			if (i == 5) nl = 8'hff;
			nd2 = pick(nl); nb2 = pick(nl); ns2 = pick(nl);
			nd3 = pick(nl); nb3 = pick(nl); ns3 = pick(nl);
			// All five flags are random here, so bits 4..0 carry meaning and are compared.
			nf2 = 5'($urandom); nf3 = 5'($urandom);
			lim <= nl; d2 <= nd2; b2 <= nb2; s2 <= ns2; d3 <= nd3; b3 <= nb3; s3 <= ns3;
			f2 <= nf2; f3 <= nf3;
			readReg(lane_health_pkg::LANE2_LINK_HEALTH_OFS, expByte(nl, nd2, nb2, ns2, nf2), "lane2");
			readReg(lane_health_pkg::LANE3_LINK_HEALTH_OFS, expByte(nl, nd3, nb3, ns3, nf3), "lane3");
		end
		idle();
		// Writes give no answer and leave the register as it was.
		@(posedge sys_clk);
		cfgWrite <= 1'b1;
		cfgAddr  <= lane_health_pkg::LANE2_LINK_HEALTH_OFS;
		repeat (2) @(posedge sys_clk);
		cfgWrite <= 1'b0;
		readReg(lane_health_pkg::LANE2_LINK_HEALTH_OFS, expByte(lim, d2, b2, s2, f2), "after write");
		cfgWrite <= 1'b1;
		idle();
		// Unmapped addresses answer with the fixed value.
		foreach (unmappedAddr[k]) begin
			readReg(unmappedAddr[k], lane_health_pkg::UNMAPPED_READ_VALUE, "unmapped");
		end
		idle();
		// With the clock enable low a pending read is not taken and the status stays frozen.
		@(posedge sys_clk);
		clkEn   <= 1'b0;
		cfgRead <= 1'b1;
		f2      <= ~f2;
		repeat (3) @(posedge sys_clk);
		clkEn   <= 1'b1;
		cfgRead <= 1'b0;
		repeat (4) @(posedge sys_clk);
		// Once enabled again the status reloads the flags changed while frozen.
		readReg(lane_health_pkg::LANE2_LINK_HEALTH_OFS, expByte(lim, d2, b2, s2, f2), "after freeze");
		idle();
		repeat (2) @(posedge sys_clk);
		check("pending answers", 8'(expQ.size()), 8'h00);
		closeOut();
	end

endmodule
